// ### hw/csbu_flag_reg.sv
// Status flag register with per-bit write enables, output from flip-flops.
`timescale 1ns/1ps
module csbu_flag_reg
  import csbu_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] wr_mask,   // Bits to be replaced.
  input  wire logic [WIDTH-1:0] wr_data,   // New values for masked bits.
  output logic      [WIDTH-1:0] flags      // Registered flag value.
);

  // ----------------------------------------------------------------------
  // Next value per bit
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] next_flags;  // Merged flag value.

  // Each bit takes new data only where its mask is set.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      assign next_flags[gi] = wr_mask[gi] ? wr_data[gi] : flags[gi];
    end
  endgenerate

  // Register the flags; reset loads a constant.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= WIDTH'(FLAGS_RESET);
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ### hw/csbu_pkg.sv
// Package of constants and types for the compare, skip and branch unit.
package csbu_pkg;

  // ----------------------------------------------------------------------
  // Status flag bit positions
  // ----------------------------------------------------------------------
  localparam int FLAG_C = 0;  // Carry.
  localparam int FLAG_Z = 1;  // Zero.
  localparam int FLAG_N = 2;  // Negative.
  localparam int FLAG_V = 3;  // Two's complement overflow.
  localparam int FLAG_S = 4;  // Sign, N xor V.
  localparam int FLAG_H = 5;  // Half carry.
  localparam int FLAG_T = 6;  // Transfer bit.
  localparam int FLAG_I = 7;  // Global interrupt enable.

  // ----------------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RESET      = 8'h00;
  localparam logic [15:0] PC_RESET         = 16'h0000;
  localparam logic [1:0]  CYC_ONE          = 2'h1;  // Single-cycle operations.
  localparam logic [1:0]  CYC_BRANCH_TAKEN = 2'h2;  // Taken branch.
  localparam logic [1:0]  CYC_SKIP_ONE     = 2'h2;  // Skip of a one-word instruction.
  localparam logic [1:0]  CYC_SKIP_TWO     = 2'h3;  // Skip of a two-word instruction.
  localparam logic [15:0] PC_STEP_ONE      = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO      = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE    = 16'h0003;

  // ----------------------------------------------------------------------
  // Operation codes presented by the decoder
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    CSBU_OP_NONE,
    CSBU_OP_COMPARE_REG_REG,
    CSBU_OP_COMPARE_REG_REG_WITH_CARRY,
    CSBU_OP_COMPARE_REG_IMMEDIATE,
    CSBU_OP_SKIP_REG_BIT_CLEAR,
    CSBU_OP_SKIP_REG_BIT_SET,
    CSBU_OP_SKIP_IO_BIT_CLEAR,
    CSBU_OP_SKIP_IO_BIT_SET,
    CSBU_OP_BRANCH_FLAG_SET,
    CSBU_OP_BRANCH_FLAG_CLEAR,
    CSBU_OP_BRANCH_EQUAL,
    CSBU_OP_BRANCH_NOT_EQUAL,
    CSBU_OP_BRANCH_CARRY_SET,
    CSBU_OP_BRANCH_CARRY_CLEAR,
    CSBU_OP_BRANCH_SAME_OR_HIGHER,
    CSBU_OP_BRANCH_LOWER,
    CSBU_OP_BRANCH_MINUS,
    CSBU_OP_BRANCH_PLUS,
    CSBU_OP_BRANCH_SIGNED_GE,
    CSBU_OP_BRANCH_SIGNED_LT,
    CSBU_OP_BRANCH_HALF_CARRY_SET,
    CSBU_OP_BRANCH_HALF_CARRY_CLEAR,
    CSBU_OP_BRANCH_TRANSFER_BIT_SET,
    CSBU_OP_BRANCH_TRANSFER_BIT_CLEAR,
    CSBU_OP_BRANCH_OVERFLOW_SET,
    CSBU_OP_BRANCH_OVERFLOW_CLEAR
  } csbu_op_e;

  // Execution state of the unit.
  typedef enum logic [1:0] {
    CSBU_ST_IDLE,
    CSBU_ST_BUSY
  } csbu_state_e;

endpackage

// ### hw/csbu_top.sv
// Compare, skip-on-bit and conditional branch execution unit of an 8-bit core.
// Overview of operation
// [RULE1] Compares subtract, discard result, set five flags; the code sets six (C, Z, N, V, S, H).
// [RULE2] Skip when register bit is clear.
// [RULE3] Skip when register bit is set.
// [RULE4] Skip when I/O register bit clear.
// [RULE5] Skip when I/O register bit set.
// [RULE6] Branch when selected status bit is one.
// [RULE7] Branch when selected status bit is zero.
// [RULE8] Equal and not-equal branches test zero.
// [RULE9] Carry, lower, same-or-higher branches test carry.
// [RULE10] Minus and plus branches test negative flag.
// [RULE11] Signed greater-or-equal when N xor V zero.
// [RULE12] Signed less-than when N xor V one.
// [RULE13] Half-carry branches test half-carry flag.
// [RULE14] Transfer-bit branches test T flag.
// [RULE15] Overflow branches test overflow, flags unchanged.
// [RULE16] Branch 1/2 cycles; skip 1/2/3 cycles.
`timescale 1ns/1ps
module csbu_top
  import csbu_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  input  wire logic            op_valid,       // Operation offered this cycle.
  input  csbu_op_e             op_code,        // Operation to execute.
  input  wire logic [7:0]      reg_a,          // Destination register operand.
  input  wire logic [7:0]      reg_b,          // Source register or immediate.
  input  wire logic [7:0]      io_value,       // Addressed I/O register value.
  input  wire logic [2:0]      bit_sel,        // Bit or status flag selector.
  input  wire logic [6:0]      branch_offset,  // Signed relative offset.
  input  wire logic            next_is_two_word, // Instruction after a skip is two words.
  input  wire logic [PC_W-1:0] pc_in,          // Address of this instruction.
  input  wire logic            flag_wr_en,     // External flag load (other groups).
  input  wire logic [7:0]      flag_wr_data,   // Flag value for external load.
  output logic                 op_ready,       // Unit can take an operation.
  output logic                 done,           // Operation finished, one-cycle pulse.
  output logic [PC_W-1:0]      pc_out,         // New program counter.
  output logic                 pc_load,        // Load pc_out, one-cycle pulse.
  output logic [1:0]           cycles_used,    // Cycles taken by last operation.
  output logic [7:0]           status_flags_register // Current status flags.
);

  // ----------------------------------------------------------------------
  // Compare arithmetic
  // ----------------------------------------------------------------------
  logic       use_carry;     // Carry-in applies to the subtraction.
  logic       is_compare;    // Operation is one of the compares.
  logic [8:0] diff;          // Nine-bit difference, bit 8 is the borrow.
  logic [4:0] diff_low;      // Low nibble difference for half carry.
  logic [7:0] cmp_flags;     // Flag values produced by a compare.
  logic [7:0] cmp_mask;      // Flags that a compare updates.
  logic       ovf;           // Signed overflow of the subtraction.

  // Subtraction with optional borrow; the result never leaves this block.
  always_comb begin
    is_compare = (op_code == CSBU_OP_COMPARE_REG_REG) ||
                 (op_code == CSBU_OP_COMPARE_REG_REG_WITH_CARRY) ||
                 (op_code == CSBU_OP_COMPARE_REG_IMMEDIATE);
    use_carry  = (op_code == CSBU_OP_COMPARE_REG_REG_WITH_CARRY);
    diff       = {1'b0, reg_a} - {1'b0, reg_b} -
                 {8'h00, use_carry & status_flags_register[FLAG_C]};  // see [RULE1]
    diff_low   = {1'b0, reg_a[3:0]} - {1'b0, reg_b[3:0]} -
                 {4'h0, use_carry & status_flags_register[FLAG_C]};
    ovf        = (reg_a[7] & ~reg_b[7] & ~diff[7]) | (~reg_a[7] & reg_b[7] & diff[7]);
    cmp_flags  = 8'h00;
    cmp_flags[FLAG_C] = diff[8];
    cmp_flags[FLAG_H] = diff_low[4];
    cmp_flags[FLAG_N] = diff[7];
    cmp_flags[FLAG_V] = ovf;
    cmp_flags[FLAG_S] = diff[7] ^ ovf;
    // With carry the zero flag can only stay or clear, so multi-byte compares chain.
    if (use_carry) begin
      cmp_flags[FLAG_Z] = (diff[7:0] == 8'h00) & status_flags_register[FLAG_Z];
    end else begin
      cmp_flags[FLAG_Z] = (diff[7:0] == 8'h00);
    end
    cmp_mask = 8'h00;
    cmp_mask[FLAG_C] = 1'b1;
    cmp_mask[FLAG_Z] = 1'b1;
    cmp_mask[FLAG_N] = 1'b1;
    cmp_mask[FLAG_V] = 1'b1;
    cmp_mask[FLAG_S] = 1'b1;
    cmp_mask[FLAG_H] = 1'b1;  // see [RULE1]
  end

  // ----------------------------------------------------------------------
  // Condition evaluation for skips and branches
  // ----------------------------------------------------------------------
  logic       is_skip;       // Operation is a skip.
  logic       is_branch;     // Operation is a branch.
  logic       cond;          // Skip or branch condition holds.
  logic [7:0] sf;            // Short alias of the flags.

  // Every branch and skip leaves the flags alone; only cond, is_skip and is_branch are produced here.
  always_comb begin
    sf        = status_flags_register;
    is_skip   = 1'b1;
    is_branch = 1'b0;
    cond      = 1'b0;
    case (op_code)
      CSBU_OP_SKIP_REG_BIT_CLEAR:        cond = ~reg_a[bit_sel];          // see [RULE2]
      CSBU_OP_SKIP_REG_BIT_SET:          cond = reg_a[bit_sel];           // see [RULE3]
      CSBU_OP_SKIP_IO_BIT_CLEAR:         cond = ~io_value[bit_sel];       // see [RULE4]
      CSBU_OP_SKIP_IO_BIT_SET:           cond = io_value[bit_sel];        // see [RULE5]
      default: begin
        is_skip   = 1'b0;
        is_branch = 1'b1;
        case (op_code)
          CSBU_OP_BRANCH_FLAG_SET:           cond = sf[bit_sel];           // see [RULE6]
          CSBU_OP_BRANCH_FLAG_CLEAR:         cond = ~sf[bit_sel];          // see [RULE7]
          CSBU_OP_BRANCH_EQUAL:              cond = sf[FLAG_Z];            // see [RULE8]
          CSBU_OP_BRANCH_NOT_EQUAL:          cond = ~sf[FLAG_Z];           // see [RULE8]
          CSBU_OP_BRANCH_CARRY_SET:          cond = sf[FLAG_C];            // see [RULE9]
          CSBU_OP_BRANCH_LOWER:              cond = sf[FLAG_C];            // see [RULE9]
          CSBU_OP_BRANCH_CARRY_CLEAR:        cond = ~sf[FLAG_C];           // see [RULE9]
          CSBU_OP_BRANCH_SAME_OR_HIGHER:     cond = ~sf[FLAG_C];           // see [RULE9]
          CSBU_OP_BRANCH_MINUS:              cond = sf[FLAG_N];            // see [RULE10]
          CSBU_OP_BRANCH_PLUS:               cond = ~sf[FLAG_N];           // see [RULE10]
          CSBU_OP_BRANCH_SIGNED_GE:          cond = ~(sf[FLAG_N] ^ sf[FLAG_V]); // see [RULE11]
          CSBU_OP_BRANCH_SIGNED_LT:          cond = sf[FLAG_N] ^ sf[FLAG_V];    // see [RULE12]
          CSBU_OP_BRANCH_HALF_CARRY_SET:     cond = sf[FLAG_H];            // see [RULE13]
          CSBU_OP_BRANCH_HALF_CARRY_CLEAR:   cond = ~sf[FLAG_H];           // see [RULE13]
          CSBU_OP_BRANCH_TRANSFER_BIT_SET:   cond = sf[FLAG_T];            // see [RULE14]
          CSBU_OP_BRANCH_TRANSFER_BIT_CLEAR: cond = ~sf[FLAG_T];           // see [RULE14]
          CSBU_OP_BRANCH_OVERFLOW_SET:       cond = sf[FLAG_V];            // see [RULE15]
          CSBU_OP_BRANCH_OVERFLOW_CLEAR:     cond = ~sf[FLAG_V];           // see [RULE15]
          default: begin
            is_branch = 1'b0;
            cond      = 1'b0;
          end
        endcase
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------------
  logic [7:0] flag_mask;     // Flags written this cycle.
  logic [7:0] flag_data;     // Values written this cycle.
  logic       accept;        // Operation is accepted this cycle.

  // A compare has priority over an external load in the same cycle,
  // since the compare is the instruction the core is actually executing.
  always_comb begin
    accept    = op_valid && op_ready;
    flag_mask = 8'h00;
    flag_data = flag_wr_data;
    if (accept && is_compare) begin
      flag_mask = cmp_mask;                 // see [RULE1]
      flag_data = cmp_flags;
    end else if (flag_wr_en) begin
      flag_mask = 8'hff;
    end
  end

  csbu_flag_reg #(
    .WIDTH (8)
  ) u_flags (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_mask (flag_mask),
    .wr_data (flag_data),
    .flags   (status_flags_register)
  );

  // ----------------------------------------------------------------------
  // Sequencer: counts out the extra cycles of taken branches and skips
  // ----------------------------------------------------------------------
  csbu_state_e      state;         // Current state.
  csbu_state_e      next_state;    // Next state.
  logic [1:0]       wait_cnt;      // Extra cycles still to spend after the current one.
  logic [1:0]       next_wait_cnt;
  logic [PC_W-1:0]  next_pc_out;
  logic             next_pc_load;
  logic             next_done;
  logic             next_op_ready;
  logic [1:0]       next_cycles_used;
  logic [1:0]       total;         // Cycles for the accepted operation.
  logic [PC_W-1:0]  target;        // Address the operation continues at.

  // pc_out takes the new PC at the accepting edge and pc_load marks it at the end of the last cycle, so
  // a consumer sees pc_load and done together after 1, 2 or 3 cycles.
  always_comb begin
    next_state       = state;
    next_wait_cnt    = wait_cnt;
    next_pc_out      = pc_out;
    next_pc_load     = 1'b0;
    next_done        = 1'b0;
    next_op_ready    = op_ready;
    next_cycles_used = cycles_used;
    total            = CYC_ONE;
    target           = pc_in + PC_W'(PC_STEP_ONE);
    if (is_branch && cond) begin
      // Sign-extended offset plus one.
      target = pc_in + {{(PC_W-7){branch_offset[6]}}, branch_offset} + PC_W'(PC_STEP_ONE);
      total  = CYC_BRANCH_TAKEN;                                      // see [RULE16]
    end else if (is_skip && cond) begin
      target = next_is_two_word ? pc_in + PC_W'(PC_STEP_THREE)
                                : pc_in + PC_W'(PC_STEP_TWO);
      total  = next_is_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;        // see [RULE16]
    end
    case (state)
      CSBU_ST_IDLE: begin
        if (accept) begin
          next_pc_out      = target;
          next_cycles_used = total;
          if (total == CYC_ONE) begin
            next_pc_load = 1'b1;
            next_done    = 1'b1;
          end else begin
            // Hold off new work while the extra cycles run.
            next_wait_cnt = total - CYC_ONE - 2'h1;
            next_op_ready = 1'b0;
            next_state    = CSBU_ST_BUSY;
          end
        end
      end
      CSBU_ST_BUSY: begin
        if (wait_cnt == 2'h0) begin
          next_pc_load  = 1'b1;
          next_done     = 1'b1;
          next_op_ready = 1'b1;
          next_state    = CSBU_ST_IDLE;
        end else begin
          next_wait_cnt = wait_cnt - 2'h1;
        end
      end
      default: begin
        next_state    = CSBU_ST_IDLE;
        next_op_ready = 1'b1;
      end
    endcase
  end

  // Register the sequencer.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state       <= CSBU_ST_IDLE;
      wait_cnt    <= 2'h0;
      pc_out      <= PC_W'(PC_RESET);
      pc_load     <= 1'b0;
      done        <= 1'b0;
      op_ready    <= 1'b1;
      cycles_used <= 2'h0;
    end else begin
      state       <= next_state;
      wait_cnt    <= next_wait_cnt;
      pc_out      <= next_pc_out;
      pc_load     <= next_pc_load;
      done        <= next_done;
      op_ready    <= next_op_ready;
      cycles_used <= next_cycles_used;
    end
  end

endmodule

// ### tb/csbu_top_assertions.sv
// Concurrent checks on the ports of the compare, skip and branch unit.
`timescale 1ns/1ps
module csbu_top_assertions
  import csbu_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic            sys_clk,
  input wire logic            rstn,
  input wire logic            op_valid,
  input csbu_op_e             op_code,
  input wire logic [7:0]      reg_a,
  input wire logic [7:0]      reg_b,
  input wire logic [7:0]      io_value,
  input wire logic [2:0]      bit_sel,
  input wire logic [6:0]      branch_offset,
  input wire logic            next_is_two_word,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic            flag_wr_en,
  input wire logic [7:0]      flag_wr_data,
  input wire logic            op_ready,
  input wire logic            done,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic            pc_load,
  input wire logic [1:0]      cycles_used,
  input wire logic [7:0]      status_flags_register
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic acc;  // An operation is taken at this edge.
  assign acc = op_valid && op_ready;

  // Sign extension of the relative offset to the counter width.
  function automatic logic [PC_W-1:0] sx(input logic [6:0] k);
    return {{(PC_W-7){k[6]}}, k};
  endfunction

  // A two-edge operation: refused once, then finished.
  sequence s_two_step;
    !op_ready ##1 (done && pc_load && op_ready && cycles_used == CYC_BRANCH_TAKEN);
  endsequence

  // A three-edge skip: refused, quiet, then finished.
  sequence s_three_step;
    !op_ready ##1 !done ##1 (done && pc_load && cycles_used == CYC_SKIP_TWO);
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_cmp_zero_carry: assert property (acc && op_code == CSBU_OP_COMPARE_REG_REG |=> done
    && pc_out == PC_W'($past(pc_in) + 1) && status_flags_register[FLAG_Z] == ($past(reg_a) == $past(reg_b))
    && status_flags_register[FLAG_C] == ($past(reg_a) < $past(reg_b))) else $error("compare result wrong");
  a_cmp_imm_half: assert property (acc && op_code == CSBU_OP_COMPARE_REG_IMMEDIATE |=> cycles_used == CYC_ONE
    && status_flags_register[FLAG_H] == ($past(reg_a[3:0]) < $past(reg_b[3:0]))) else $error("immediate compare wrong");
  a_skip_reg_clear: assert property (acc && op_code == CSBU_OP_SKIP_REG_BIT_CLEAR && !reg_a[bit_sel]
    && !next_is_two_word |=> s_two_step ##0 (pc_out == PC_W'($past(pc_in, 2) + 2))) else $error("skip over one word wrong");
  a_skip_io_two: assert property (acc && op_code == CSBU_OP_SKIP_IO_BIT_SET && io_value[bit_sel]
    && next_is_two_word |=> s_three_step ##0 (pc_out == PC_W'($past(pc_in, 3) + 3))) else $error("skip over two words wrong");
  a_branch_equal_taken: assert property (acc && op_code == CSBU_OP_BRANCH_EQUAL && status_flags_register[FLAG_Z]
    |=> s_two_step ##0 (pc_out == PC_W'($past(pc_in, 2) + sx($past(branch_offset, 2)) + 1))) else $error("taken branch wrong");
  a_branch_ge_idle: assert property (acc && op_code == CSBU_OP_BRANCH_SIGNED_GE
    && (status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V]) |=> done && op_ready
    && cycles_used == CYC_ONE && pc_out == PC_W'($past(pc_in) + 1)) else $error("untaken branch wrong");
  a_flags_kept: assert property (acc && op_code >= CSBU_OP_SKIP_REG_BIT_CLEAR && !flag_wr_en
    |=> $stable(status_flags_register)) else $error("skip or branch changed flags");
  a_done_with_load: assert property (done |-> pc_load && op_ready) else $error("done without load");
endmodule

bind csbu_top csbu_top_assertions #(.PC_W(PC_W)) i_csbu_top_assertions (.sys_clk(sys_clk), .rstn(rstn),
  .op_valid(op_valid), .op_code(op_code), .reg_a(reg_a), .reg_b(reg_b), .io_value(io_value), .bit_sel(bit_sel),
  .branch_offset(branch_offset), .next_is_two_word(next_is_two_word), .pc_in(pc_in), .flag_wr_en(flag_wr_en),
  .flag_wr_data(flag_wr_data), .op_ready(op_ready), .done(done), .pc_out(pc_out), .pc_load(pc_load),
  .cycles_used(cycles_used), .status_flags_register(status_flags_register));

// ### tb/csbu_top_tb_top.sv
// Self-checking testbench for the compare, skip and branch unit.
`timescale 1ns/1ps
module csbu_top_tb_top
  import csbu_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        sys_clk, rstn, op_valid, next_is_two_word, flag_wr_en;
  csbu_op_e    op_code;
  logic [7:0]  reg_a, reg_b, io_value, flag_wr_data, status_flags_register;
  logic [7:0]  fl;  // Expected flags, kept by the bench.
  logic [2:0]  bit_sel;
  logic [6:0]  branch_offset;
  logic [15:0] pc_in, pc_out;
  logic        op_ready, done, pc_load;
  logic [1:0]  cycles_used;
  int          err_total, total_checks, cyc_count;

  csbu_top i_csbu_top (.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .reg_a(reg_a),
    .reg_b(reg_b), .io_value(io_value), .bit_sel(bit_sel), .branch_offset(branch_offset),
    .next_is_two_word(next_is_two_word), .pc_in(pc_in), .flag_wr_en(flag_wr_en), .flag_wr_data(flag_wr_data),
    .op_ready(op_ready), .done(done), .pc_out(pc_out), .pc_load(pc_load), .cycles_used(cycles_used),
    .status_flags_register(status_flags_register));

  // ----------------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Loads all flags the way other instruction groups would.
  task automatic set_flags(input logic [7:0] v);
    @(posedge sys_clk);
    #1;
    flag_wr_en = 1'b1;
    flag_wr_data = v;
    @(posedge sys_clk);
    #1;
    flag_wr_en = 1'b0;
    fl = v;
  endtask

  // Offers the prepared operation once and judges its completion.
  task automatic go(input logic [15:0] exp_pc, input logic [1:0] exp_cyc, input string msg);
    int n;
    n = 1;
    @(posedge sys_clk);
    #1;
    op_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    op_valid = 1'b0;
    while (done !== 1'b1 && n < 5) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(pc_load === 1'b1 && pc_out === exp_pc && cycles_used === exp_cyc && n == exp_cyc, msg);
    chk(status_flags_register === fl, msg);
  endtask

  // Reference subtraction flags; carry in and zero chaining only for the carry form.
  function automatic logic [7:0] cmp_flags(input logic [7:0] a, b, f, input logic c, chain);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] o;
    r = {1'b0, a} - {1'b0, b} - c;
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - c;
    o = f;
    o[FLAG_C] = r[8];
    o[FLAG_Z] = (r[7:0] == 8'h00) && (!chain || f[FLAG_Z]);
    o[FLAG_N] = r[7];
    o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
    o[FLAG_H] = h[4];
    return o;
  endfunction

  // Branch condition of each conditional branch.
  function automatic logic taken(input csbu_op_e op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      CSBU_OP_BRANCH_FLAG_SET: return f[s];
      CSBU_OP_BRANCH_FLAG_CLEAR: return !f[s];
      CSBU_OP_BRANCH_EQUAL: return f[FLAG_Z];
      CSBU_OP_BRANCH_NOT_EQUAL: return !f[FLAG_Z];
      CSBU_OP_BRANCH_CARRY_SET, CSBU_OP_BRANCH_LOWER: return f[FLAG_C];
      CSBU_OP_BRANCH_CARRY_CLEAR, CSBU_OP_BRANCH_SAME_OR_HIGHER: return !f[FLAG_C];
      CSBU_OP_BRANCH_MINUS: return f[FLAG_N];
      CSBU_OP_BRANCH_PLUS: return !f[FLAG_N];
      CSBU_OP_BRANCH_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
      CSBU_OP_BRANCH_SIGNED_LT: return f[FLAG_N] ^ f[FLAG_V];
      CSBU_OP_BRANCH_HALF_CARRY_SET: return f[FLAG_H];
      CSBU_OP_BRANCH_HALF_CARRY_CLEAR: return !f[FLAG_H];
      CSBU_OP_BRANCH_TRANSFER_BIT_SET: return f[FLAG_T];
      CSBU_OP_BRANCH_TRANSFER_BIT_CLEAR: return !f[FLAG_T];
      CSBU_OP_BRANCH_OVERFLOW_SET: return f[FLAG_V];
      default: return !f[FLAG_V];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // All three compares over borrow, overflow and half-borrow corners.
  task automatic t_compare;
    logic [7:0] av [5] = '{8'h10, 8'h00, 8'h80, 8'h7f, 8'h18};
    logic [7:0] bv [5] = '{8'h10, 8'h01, 8'h01, 8'hff, 8'h09};
    set_flags(8'hc3);
    for (int i = 0; i < 15; i++) begin
      op_code = csbu_op_e'(int'(CSBU_OP_COMPARE_REG_REG) + i / 5);
      reg_a = av[i % 5];
      reg_b = bv[i % 5];
      fl = cmp_flags(reg_a, reg_b, fl, (i / 5 == 1) && fl[FLAG_C], i / 5 == 1);
      go(pc_in + 16'h0001, CYC_ONE, "compare");
    end
  endtask

  // Every skip, bit value and following-word size; the unused source shows the opposite bit.
  task automatic t_skip;
    logic hit;
    for (int i = 0; i < 16; i++) begin
      op_code = csbu_op_e'(int'(CSBU_OP_SKIP_REG_BIT_CLEAR) + i % 4);
      bit_sel = 3'(i * 3);
      next_is_two_word = i[3];
      reg_a = i[2] ? (8'h01 << bit_sel) : ~(8'h01 << bit_sel);
      io_value = ~reg_a;
      hit = ((i % 4 < 2) ? reg_a[bit_sel] : io_value[bit_sel]) == i[0];
      go(hit ? pc_in + (i[3] ? 16'h0003 : 16'h0002) : pc_in + 16'h0001,
         hit ? (i[3] ? CYC_SKIP_TWO : CYC_SKIP_ONE) : CYC_ONE, "skip");
    end
  endtask

  // Every branch against flag patterns that keep S equal to N xor V.
  task automatic t_branch;
    logic [7:0] pat [5] = '{8'h00, 8'hef, 8'h15, 8'h3a, 8'h0c};
    logic [15:0] tgt;
    for (int p = 0; p < 5; p++) begin
      set_flags(pat[p]);
      for (int o = CSBU_OP_BRANCH_FLAG_SET; o <= CSBU_OP_BRANCH_OVERFLOW_CLEAR; o++) begin
        op_code = csbu_op_e'(o);
        bit_sel = 3'(o + p);
        branch_offset = o[0] ? 7'h40 : 7'h3f;
        tgt = pc_in + {{9{branch_offset[6]}}, branch_offset} + 16'h0001;
        go(taken(op_code, fl, bit_sel) ? tgt : pc_in + 16'h0001,
           taken(op_code, fl, bit_sel) ? CYC_BRANCH_TAKEN : CYC_ONE, "branch");
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // About 330 cycles are needed; the ceiling leaves ample margin.
  always @(posedge sys_clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    {rstn, op_valid, next_is_two_word, flag_wr_en} = 4'h0;
    op_code = CSBU_OP_NONE;
    {reg_a, reg_b, io_value, flag_wr_data, fl} = 40'h0;
    bit_sel = 3'h0;
    branch_offset = 7'h00;
    pc_in = 16'h0200;
    repeat (16) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk(op_ready === 1'b1 && done === 1'b0 && pc_load === 1'b0 && pc_out === 16'h0000
        && cycles_used === 2'h0 && status_flags_register === FLAGS_RESET, "reset");
    t_compare();
    t_skip();
    t_branch();
    wrap_up();
  end
endmodule
